// ==== logic/fhm_pkg.sv ====
// Constants shared by the flash headroom and general control registers.
// Assumes a single 40 MHz core clock and an I2C-style serial host.
`default_nettype none

package fhm_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLASH_LIMITS_OFF = 8'h35;
  localparam logic [7:0] GEN_CTRL_OFF     = 8'h36;
  localparam logic [7:0] FLASH_LIMITS_RST = 8'h00;
  localparam logic [7:0] GEN_CTRL_RST     = 8'h00;
  localparam logic [7:0] GEN_CTRL_WMASK   = 8'hEF; // Bit 4 unused
  localparam logic [7:0] UNMAPPED_RDATA   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int START_MSB    = 7;
  localparam int START_LSB    = 4;
  localparam int CEIL_MSB     = 3;
  localparam int CEIL_LSB     = 0;
  localparam int VAR_SRC_BIT  = 7;
  localparam int IRQ_SRC_BIT  = 6;
  localparam int LOW_PWR_BIT  = 5;
  localparam int BOOST_BIT    = 3;
  localparam int GRP_DIM_BIT  = 2;
  localparam int PWM_SRC_BIT  = 1;
  localparam int INT_CLK_BIT  = 0;

  // ----------------------------------------------------------------------
  // Headroom voltage coding, in millivolts
  // ----------------------------------------------------------------------
  localparam logic [10:0] HR_BASE_MV     = 11'h12C; // 300 mV at code 0
  localparam logic [10:0] HR_STEP_MV     = 11'h064; // 100 mV per code
  localparam logic [3:0]  START_TOP_CODE = 4'h4;    // 700 mV
  localparam logic [3:0]  CEIL_TOP_CODE  = 4'hA;    // 1300 mV

  // ----------------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
    S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } fhm_state_t;

endpackage : fhm_pkg

`default_nettype wire

// ==== logic/fhm_cfg_if.sv ====
// Carries the two stored register bytes from the serial front end to the
// decode stage. Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none

interface fhm_cfg_if;
  logic [7:0] flash_byte;
  logic [7:0] ctrl_byte;

  modport src (output flash_byte, output ctrl_byte);
  modport dst (input flash_byte, input ctrl_byte);
endinterface : fhm_cfg_if

`default_nettype wire

// ==== logic/fhm_cfg_decode.sv ====
// Turns the stored register bytes into registered controls and routes the
// selectable sources. Assumes ext_pwm_pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module fhm_cfg_decode
  import fhm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Stored register bytes
  fhm_cfg_if.dst           cfg,
  // Selectable sources
  input  wire logic [7:0]  var_d_host,
  input  wire logic [7:0]  var_d_adc,
  input  wire logic        zone_change_irq,
  input  wire logic        engine_irq,
  input  wire logic        haptic_pwm,
  input  wire logic        ext_pwm_pin,
  // Decoded controls
  output logic      [10:0] headroom_start_mv,
  output logic      [10:0] headroom_max_mv,
  output logic      [7:0]  var_d,
  output logic             irq_out,
  output logic             dbc_pwm,
  output logic             low_power_enable,
  output logic             boost_enable,
  output logic             group_dim_on_disable,
  output logic             int_clk_select
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [10:0] code_mv(input logic [3:0] c);
    code_mv = HR_BASE_MV + 11'(c) * HR_STEP_MV;
  endfunction : code_mv

  // Codes past the top defined step hold that step
  function automatic logic [3:0] clamp(input logic [3:0] c,
                                       input logic [3:0] top);
    clamp = (c > top) ? top : c;
  endfunction : clamp

  logic       ext_s1_r;
  logic       ext_s2_r;
  logic       ext_s3_r;
  logic       ext_f_r;
  logic [3:0] start_code;
  logic [3:0] ceil_code;

  assign start_code = cfg.flash_byte[START_MSB:START_LSB];
  assign ceil_code  = cfg.flash_byte[CEIL_MSB:CEIL_LSB];

  // ----------------------------------------------------------------------
  // External PWM pin synchroniser; glitches shorter than a cycle are lost
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_f_r  <= 1'b0;
    end else begin
      ext_s1_r <= ext_pwm_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_f_r <= ext_s3_r;
      end
    end
  end

  // Headroom targets, clamped to the defined steps
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      headroom_start_mv <= HR_BASE_MV;
      headroom_max_mv   <= HR_BASE_MV;
    end else begin
      headroom_start_mv <= code_mv(clamp(start_code, START_TOP_CODE)); // see [R1] [R10]
      headroom_max_mv   <= code_mv(clamp(ceil_code, CEIL_TOP_CODE));  // see [R2] [R10]
    end
  end

  // Plain enables and source routing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      var_d                <= 8'h00;
      irq_out              <= 1'b0;
      dbc_pwm              <= 1'b0;
      low_power_enable     <= 1'b0;
      boost_enable         <= 1'b0;
      group_dim_on_disable <= 1'b0;
      int_clk_select       <= 1'b0;
    end else begin
      var_d   <= cfg.ctrl_byte[VAR_SRC_BIT] ? var_d_adc : var_d_host; // see [R3]
      irq_out <= cfg.ctrl_byte[IRQ_SRC_BIT] ? engine_irq
                                            : zone_change_irq;        // see [R4]
      dbc_pwm <= cfg.ctrl_byte[PWM_SRC_BIT] ? ext_f_r : haptic_pwm;   // see [R8]
      low_power_enable     <= cfg.ctrl_byte[LOW_PWR_BIT];  // see [R5]
      boost_enable         <= cfg.ctrl_byte[BOOST_BIT];    // see [R6]
      group_dim_on_disable <= cfg.ctrl_byte[GRP_DIM_BIT];  // see [R7]
      int_clk_select       <= cfg.ctrl_byte[INT_CLK_BIT];  // see [R9]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  start_target_a: assert property ( // see [R1]
    start_code <= START_TOP_CODE |=>
      headroom_start_mv == 11'h12C + 11'h064 * 11'($past(start_code)))
    else $error("headroom start target wrong");
  ceil_target_a: assert property ( // see [R2]
    ceil_code == 4'hA |=> headroom_max_mv == 11'h514)
    else $error("headroom ceiling target wrong");
  reserved_hold_a: assert property ( // see [R10]
    (start_code > 4'h4) && (ceil_code > 4'hA) |=>
      headroom_start_mv == 11'h2BC && headroom_max_mv == 11'h514)
    else $error("reserved headroom code not held");
  var_route_a: assert property ( // see [R3]
    cfg.ctrl_byte[7] |=> var_d == $past(var_d_adc))
    else $error("variable source not from converter");
  irq_route_a: assert property ( // see [R4]
    !cfg.ctrl_byte[6] && zone_change_irq |=> irq_out)
    else $error("zone change interrupt not routed");
  low_power_a: assert property ( // see [R5]
    $rose(cfg.ctrl_byte[5]) |=> low_power_enable)
    else $error("power save not enabled");
  boost_en_a: assert property ( // see [R6]
    !cfg.ctrl_byte[3] |=> !boost_enable)
    else $error("boost enabled while bit clear");
  group_dim_a: assert property ( // see [R7]
    1'b1 |=> group_dim_on_disable == $past(cfg.ctrl_byte[2]))
    else $error("fade enable does not follow bit");
  pwm_route_a: assert property ( // see [R8]
    !cfg.ctrl_byte[1] ##1 !cfg.ctrl_byte[1] |->
      dbc_pwm == $past(haptic_pwm))
    else $error("haptic pwm not routed");
  clk_select_a: assert property ( // see [R9]
    cfg.ctrl_byte[0] [*2] |-> int_clk_select)
    else $error("internal clock not selected");

endmodule : fhm_cfg_decode

`default_nettype wire

// ==== logic/fhm_regs.sv ====
// Flash headroom limits and general control registers behind a serial
// two-wire slave port. Assumes scl and sda come from pins in another
// clock domain and that the pad resolves sda from sda_oe (open drain).
//
// How it works
// [R1] Bits 7:4 of flash limits pick start voltage, 300 to 700 mV.
// [R2] Bits 3:0 of flash limits pick ceiling voltage, 300 to 1300 mV.
// [R3] Control bit 7 takes variable D from converter, else host register.
// [R4] Control bit 6 takes interrupt from engines, else ambient zone change.
// [R5] Control bit 5 enables power-save mode.
// [R6] Control bit 3 enables the boost converter.
// [R7] Control bit 2 fades group outputs to off on disable.
// [R8] Control bit 1 feeds external PWM pin, else haptic PWM, to backlight.
// [R9] Control bit 0 selects internal oscillator, else external clock.
// [R10] Undefined headroom codes hold the last defined voltage step.
`timescale 1ns/1ps
`default_nettype none

module fhm_regs
  import fhm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h1A  // Arbitrary slave address
)(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Serial port pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Selectable sources
  input  wire logic [7:0]  var_d_host,
  input  wire logic [7:0]  var_d_adc,
  input  wire logic        zone_change_irq,
  input  wire logic        engine_irq,
  input  wire logic        haptic_pwm,
  input  wire logic        ext_pwm_pin,
  // Decoded controls
  output logic      [10:0] headroom_start_mv,
  output logic      [10:0] headroom_max_mv,
  output logic      [7:0]  var_d,
  output logic             irq_out,
  output logic             dbc_pwm,
  output logic             low_power_enable,
  output logic             boost_enable,
  output logic             group_dim_on_disable,
  output logic             int_clk_select
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [2:0] scl_s_r;     // [0] first stage, read only by [1]
  logic [2:0] sda_s_r;
  logic       scl_f_r;
  logic       sda_f_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_rise;
  logic       sda_fall;
  logic       start_det;
  logic       stop_det;
  fhm_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic       rw_r;
  logic       nack_r;
  logic       sda_oe_r;
  logic       byte_done;
  logic       wr_stb;
  logic [7:0] rd_byte;
  logic [7:0] flash_r;
  logic [7:0] ctrl_r;

  fhm_cfg_if cfg ();

  // ----------------------------------------------------------------------
  // Pin synchronisers; a level counts once stages two and three agree
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
    end
  end

  // Edges of the filtered levels
  assign scl_rise  = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_f_r;
  assign scl_fall  = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_f_r;
  assign sda_rise  = (sda_s_r[1] == sda_s_r[2]) && sda_s_r[2] && !sda_f_r;
  assign sda_fall  = (sda_s_r[1] == sda_s_r[2]) && !sda_s_r[2] && sda_f_r;
  assign start_det = sda_fall && scl_f_r;
  assign stop_det  = sda_rise && scl_f_r;
  assign byte_done = (cnt_r == BYTE_BITS);

  // A data byte is stored on the falling clock after its eighth bit
  assign wr_stb = scl_fall && !start_det && !stop_det &&
                  (state_r == S_WR) && byte_done;

  // ----------------------------------------------------------------------
  // Read mux; unmapped offsets read as zero and bit 4 of control as zero
  // ----------------------------------------------------------------------
  always_comb begin
    case (ptr_r)
      FLASH_LIMITS_OFF: rd_byte = flash_r;
      GEN_CTRL_OFF:     rd_byte = ctrl_r & GEN_CTRL_WMASK;
      default:          rd_byte = UNMAPPED_RDATA;
    endcase
  end

  // ----------------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------------
  // Sda only moves on the falling clock so the host never sees a false
  // start or stop from us; the pointer auto-increments on every data byte.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r  <= S_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r  <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r  <= S_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        S_ADDR, S_PTR, S_WR: begin
          shift_r <= {shift_r[6:0], sda_f_r};
          cnt_r   <= cnt_r + 4'h1;
        end
        S_RD: begin
          cnt_r <= cnt_r + 4'h1;
        end
        S_RD_ACK: begin
          nack_r <= sda_f_r;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_r)
        S_ADDR: begin
          if (byte_done) begin
            if (shift_r[7:1] == DEV_ADDR) begin
              state_r  <= S_ADDR_ACK;
              rw_r     <= shift_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_PTR: begin
          if (byte_done) begin
            ptr_r    <= shift_r;
            state_r  <= S_PTR_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        S_WR: begin
          if (byte_done) begin
            ptr_r    <= ptr_r + 8'h01;
            state_r  <= S_WR_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        S_ADDR_ACK: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            shift_r  <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
            state_r  <= S_RD;
          end else begin
            sda_oe_r <= 1'b0;
            state_r  <= S_PTR;
          end
        end
        S_PTR_ACK, S_WR_ACK: begin
          cnt_r    <= 4'h0;
          sda_oe_r <= 1'b0;
          state_r  <= S_WR;
        end
        S_RD: begin
          if (byte_done) begin
            ptr_r    <= ptr_r + 8'h01;
            sda_oe_r <= 1'b0;
            state_r  <= S_RD_ACK;
          end else begin
            shift_r  <= {shift_r[6:0], 1'b0};
            sda_oe_r <= ~shift_r[6];
          end
        end
        S_RD_ACK: begin
          cnt_r <= 4'h0;
          if (nack_r) begin
            state_r <= S_IDLE;
          end else begin
            shift_r  <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
            state_r  <= S_RD;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flash_r <= FLASH_LIMITS_RST;
      ctrl_r  <= GEN_CTRL_RST;
    end else if (wr_stb) begin
      case (ptr_r)
        FLASH_LIMITS_OFF: flash_r <= shift_r;                 // see [R1] [R2]
        GEN_CTRL_OFF:     ctrl_r  <= shift_r & GEN_CTRL_WMASK; // see [R3]
        default: begin
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_r;

  assign cfg.flash_byte = flash_r;
  assign cfg.ctrl_byte  = ctrl_r;

  // ----------------------------------------------------------------------
  // Decode stage
  // ----------------------------------------------------------------------
  fhm_cfg_decode u_decode (
    .core_clk             (core_clk),
    .rstn                 (rstn),
    .cfg                  (cfg),
    .var_d_host           (var_d_host),
    .var_d_adc            (var_d_adc),
    .zone_change_irq      (zone_change_irq),
    .engine_irq           (engine_irq),
    .haptic_pwm           (haptic_pwm),
    .ext_pwm_pin          (ext_pwm_pin),
    .headroom_start_mv    (headroom_start_mv),
    .headroom_max_mv      (headroom_max_mv),
    .var_d                (var_d),
    .irq_out              (irq_out),
    .dbc_pwm              (dbc_pwm),
    .low_power_enable     (low_power_enable),
    .boost_enable         (boost_enable),
    .group_dim_on_disable (group_dim_on_disable),
    .int_clk_select       (int_clk_select)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence ctrl_write_s;
    wr_stb && (ptr_r == 8'h36);
  endsequence

  sequence boost_follows_s;
    1'b1 ##2 (boost_enable == $past(shift_r[3], 2));
  endsequence

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  ctrl_store_a: assert property ( // see [R6]
    ctrl_write_s |-> boost_follows_s)
    else $error("boost enable does not follow control write");

  flash_store_a: assert property ( // see [R1]
    wr_stb && (ptr_r == 8'h35) |=> flash_r == $past(shift_r))
    else $error("flash limits write lost");

endmodule : fhm_regs

`default_nettype wire

// ==== verification/fhm_i2c_host.sv ====
// Host side model: a two-wire serial controller that writes and reads
// registers. Assumes a pull-up on sda and that the device pulls sda low.
`timescale 1ns/1ps
`default_nettype none

module fhm_i2c_host (
  // Clock
  input  wire logic core_clk,
  // Bus lines
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // --------------------------------------------------------------------
  // Bit level, 20 core clocks per bit so each phase clears the filter
  // --------------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  // Data moves mid-low so it never crosses the filtered clock edge
  task automatic bit_out(input logic b);
    tick(4);
    sda_low = !b;
    tick(6);
    scl = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic b);
    tick(4);
    sda_low = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(5);
    b = sda_in;
    tick(5);
    scl = 1'b0;
  endtask : bit_in

  // Serves as both first and repeated start
  task automatic start();
    tick(4);
    sda_low = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(4);
    sda_low = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask : stop

  // --------------------------------------------------------------------
  // Byte level and register transfers
  // --------------------------------------------------------------------
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic nb;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(nb);
    ack = !nb;
  endtask : byte_out

  task automatic byte_in(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(last);
  endtask : byte_in

  task automatic wr(input logic [6:0] a, input logic [7:0] off,
                    input logic [7:0] q[$], output logic ok);
    logic k;
    start();
    byte_out({a, 1'b0}, k);
    ok = k;
    byte_out(off, k);
    ok = ok & k;
    foreach (q[i]) begin
      byte_out(q[i], k);
      ok = ok & k;
    end
    stop();
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] off,
                    input int n, output logic [7:0] q[$]);
    logic       k;
    logic [7:0] d;
    q = {};
    start();
    byte_out({a, 1'b0}, k);
    byte_out(off, k);
    start();
    byte_out({a, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      byte_in(i == n - 1, d);
      q.push_back(d);
    end
    stop();
  endtask : rd

endmodule : fhm_i2c_host

`default_nettype wire

// ==== verification/flash_headroom_misc_config_tb_top.sv ====
// Self-checking bench for the headroom and general control registers.
// Assumes the host model above and a pulled-up sda line.
`timescale 1ns/1ps
`default_nettype none

module flash_headroom_misc_config_tb_top;
  import fhm_pkg::*;

  localparam logic [6:0] DEV = 7'h1A;

  logic        core_clk, rstn, scl, sda_low, sda_o, sda_oe, ok;
  logic [7:0]  var_d_host, var_d_adc, var_d;
  logic        zone_change_irq, engine_irq, haptic_pwm, ext_pwm_pin;
  logic [10:0] headroom_start_mv, headroom_max_mv;
  logic        irq_out, dbc_pwm, low_power_enable, boost_enable;
  logic        group_dim_on_disable, int_clk_select;
  logic [7:0]  q[$];
  logic [7:0]  v;
  logic [7:0]  pat[9] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02,
                          8'h01, 8'hFF};
  int          err_total, n_checks;
  // Pull-up; the pad drives sda_o only while sda_oe is high
  wire         sda = !sda_low && (sda_oe ? sda_o : 1'b1);

  fhm_i2c_host i_host (.core_clk(core_clk), .sda_in(sda), .scl(scl),
                       .sda_low(sda_low));

  fhm_regs #(.DEV_ADDR(DEV)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .var_d_host(var_d_host),
    .var_d_adc(var_d_adc), .zone_change_irq(zone_change_irq),
    .engine_irq(engine_irq), .haptic_pwm(haptic_pwm),
    .ext_pwm_pin(ext_pwm_pin), .headroom_start_mv(headroom_start_mv),
    .headroom_max_mv(headroom_max_mv), .var_d(var_d), .irq_out(irq_out),
    .dbc_pwm(dbc_pwm), .low_power_enable(low_power_enable),
    .boost_enable(boost_enable),
    .group_dim_on_disable(group_dim_on_disable),
    .int_clk_select(int_clk_select));

  // --------------------------------------------------------------------
  // Clock, checks and closing report
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t read %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk_rd

  task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t output %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk_out

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
      err_total++;
    end
  endtask : chk_bit

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Codes above the top defined step hold that step
  function automatic logic [10:0] mv(input logic [3:0] c,
                                     input logic [3:0] top);
    return 11'((c > top ? top : c) * 100 + 300);
  endfunction : mv

  // Every wait is a fixed count; this only cuts a hung run short
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    test_done();
  end

  // --------------------------------------------------------------------
  // Tests; sources differ so every select shows at its output
  // --------------------------------------------------------------------
  initial begin
    err_total = 0;
    n_checks = 0;
    rstn = 1'b0;
    var_d_host = 8'h5A;
    var_d_adc = 8'hA5;
    zone_change_irq = 1'b1;
    engine_irq = 1'b0;
    haptic_pwm = 1'b1;
    ext_pwm_pin = 1'b0;
    repeat (8) @(posedge core_clk);
    #2 rstn = 1'b1;
    i_host.tick(8);
    chk_out(headroom_start_mv, HR_BASE_MV);
    chk_out(headroom_max_mv, HR_BASE_MV);
    i_host.rd(DEV, FLASH_LIMITS_OFF, 2, q);
    chk_rd(q[0], FLASH_LIMITS_RST);
    chk_rd(q[1], GEN_CTRL_RST);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      v = {c[3:0], c[3:0]};
      i_host.wr(DEV, FLASH_LIMITS_OFF, '{v}, ok);
      i_host.tick(10);
      chk_out(headroom_start_mv, mv(c[3:0], 4'h4));
      chk_out(headroom_max_mv, mv(c[3:0], 4'hA));
      i_host.rd(DEV, FLASH_LIMITS_OFF, 1, q);
      chk_rd(q[0], v);
    end
    $display("test headroom done");
    foreach (pat[i]) begin
      v = pat[i];
      i_host.wr(DEV, GEN_CTRL_OFF, '{v}, ok);
      i_host.tick(10);
      chk_out(11'(var_d), 11'(v[7] ? var_d_adc : var_d_host));
      chk_bit(irq_out, v[6] ? engine_irq : zone_change_irq);
      chk_bit(low_power_enable, v[5]);
      chk_bit(boost_enable, v[3]);
      chk_bit(group_dim_on_disable, v[2]);
      chk_bit(dbc_pwm, v[1] ? ext_pwm_pin : haptic_pwm);
      chk_bit(int_clk_select, v[0]);
      i_host.rd(DEV, GEN_CTRL_OFF, 1, q);
      chk_rd(q[0], v & GEN_CTRL_WMASK);
    end
    // Both selects are set now; flip the sources so each path must move
    engine_irq = 1'b1;
    ext_pwm_pin = 1'b1;
    i_host.tick(10);
    chk_bit(irq_out, 1'b1);
    chk_bit(dbc_pwm, 1'b1);
    $display("test control done");
    i_host.wr(DEV, FLASH_LIMITS_OFF, '{8'hA3, 8'h5C, 8'h77}, ok);
    chk_bit(ok, 1'b1);
    i_host.rd(DEV, 8'h34, 4, q);
    chk_rd(q[0], UNMAPPED_RDATA);
    chk_rd(q[1], 8'hA3);
    chk_rd(q[2], 8'h5C & GEN_CTRL_WMASK);
    chk_rd(q[3], UNMAPPED_RDATA);
    $display("test burst done");
    i_host.wr(DEV ^ 7'h01, GEN_CTRL_OFF, '{8'h00}, ok);
    chk_bit(ok, 1'b0);
    i_host.tick(10);
    chk_bit(boost_enable, 1'b1);
    chk_bit(group_dim_on_disable, 1'b1);
    $display("test wrong address done");
    test_done();
  end

endmodule : flash_headroom_misc_config_tb_top

`default_nettype wire
